// ### logic/spicfg_pkg.sv
// Constants for the serial configuration and reset register bank
package spicfg_pkg;
	localparam int SPICFG_ADDR_W = 15;
	localparam int SPICFG_INSTR_BITS = 16;
	localparam int SPICFG_WORD_BITS = 8;
	localparam int SPICFG_CHANNELS = 2;
	// Register offsets
	localparam logic [14:0] SPICFG_SETUP_A_ADDR = 15'h0000;
	localparam logic [14:0] SPICFG_SETUP_B_ADDR = 15'h0001;
	localparam logic [14:0] SPICFG_POWER_ADDR = 15'h0002;
	localparam logic [14:0] SPICFG_CHSEL_ADDR = 15'h0008;
	// Field positions, primary setup register
	localparam int SPICFG_A_SOFT_RST = 0;
	localparam int SPICFG_A_LSB_FIRST = 1;
	localparam int SPICFG_A_ADDR_INC = 2;
	localparam int SPICFG_A_ADDR_INC_M = 5;
	localparam int SPICFG_A_LSB_FIRST_M = 6;
	localparam int SPICFG_A_SOFT_RST_M = 7;
	// Field positions, secondary setup register
	localparam int SPICFG_B_DP_RST = 1;
	// Reset values
	localparam logic SPICFG_LSB_FIRST_RST = 1'b0;
	localparam logic SPICFG_ADDR_INC_RST = 1'b0;
	localparam logic [1:0] SPICFG_POWER_RST = 2'h0;
	localparam logic [1:0] SPICFG_CHSEL_RST = 2'h3;
	// Channel power encodings
	localparam logic [1:0] SPICFG_PWR_NORMAL = 2'h0;
	localparam logic [1:0] SPICFG_PWR_STANDBY = 2'h2;
	localparam logic [1:0] SPICFG_PWR_DOWN = 2'h3;
	// Serial port states
	typedef enum logic [1:0] {
		SPICFG_ST_INSTR,
		SPICFG_ST_DATA,
		SPICFG_ST_HOLD
	} spicfg_state_t;
endpackage

// ### logic/spicfg_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spicfg_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			logic ff1;
			logic ff2;
			logic ff3;
			logic next_level;
			// The first stage feeds only the second
			always_comb begin
				next_level = (ff2 == ff3) ? ff3 : level_out[i];
			end
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					ff1 <= INIT[i];
					ff2 <= INIT[i];
					ff3 <= INIT[i];
					level_out[i] <= INIT[i];
				end else begin
					ff1 <= pin_in[i];
					ff2 <= ff1;
					ff3 <= ff2;
					level_out[i] <= next_level;
				end
			end
		end
	endgenerate
endmodule // spicfg_sync

// ### logic/spicfg_regs.sv
// Serial port slave with configuration, reset and power registers
`timescale 1ns/1ps
module spicfg_regs
	import spicfg_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Serial pins
	input wire logic spi_sclk,
	input wire logic select_low_input_n,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe,
	// Reset strobes to the rest of the chip
	output logic soft_reset_pulse,
	output logic datapath_reset_pulse,
	// Configuration state
	output logic lsb_first,
	output logic addr_inc,
	output logic [2*SPICFG_CHANNELS-1:0] chan_power_mode,
	// Per-channel power controls
	output logic [SPICFG_CHANNELS-1:0] datapath_clk_en,
	output logic [SPICFG_CHANNELS-1:0] datapath_hold_reset,
	output logic [SPICFG_CHANNELS-1:0] link_enable
);
	////////////////////////////////////////////////////////////////////////
	logic sclk_s;
	logic csb_s;
	logic sdi_s;
	spicfg_sync #(.WIDTH(3), .INIT(3'h2)) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_in({spi_sclk, select_low_input_n, sdio_in}),
		.level_out({sclk_s, csb_s, sdi_s})
	);

	////////////////////////////////////////////////////////////////////////
	spicfg_state_t st;
	spicfg_state_t next_st;
	logic sclk_q;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic rw;
	logic next_rw;
	logic [14:0] addr;
	logic [14:0] next_addr;
	logic [7:0] rd_byte;
	logic [7:0] next_rd_byte;
	logic next_sdio_out;
	logic next_sdio_oe;
	logic next_soft;
	logic next_dp;
	logic next_lsb_first;
	logic next_addr_inc;
	logic [1:0] ch_sel;
	logic [1:0] next_ch_sel;
	logic [2*SPICFG_CHANNELS-1:0] next_power;
	logic rise;
	logic fall;
	logic byte_done;
	logic out_lsb;
	logic [7:0] setup_a_rd;

	assign rise = sclk_s & ~sclk_q;
	assign fall = ~sclk_s & sclk_q;
	assign byte_done = !csb_s && st == SPICFG_ST_DATA && rise &&
		bit_cnt == 4'h7;
	assign out_lsb = rd_byte[bit_cnt[2:0]];

	// Mirror bits are copies; the reset bit always reads back as zero
	always_comb begin
		setup_a_rd = 8'h00;
		setup_a_rd[SPICFG_A_LSB_FIRST] = lsb_first;
		setup_a_rd[SPICFG_A_LSB_FIRST_M] = lsb_first;
		setup_a_rd[SPICFG_A_ADDR_INC] = addr_inc;
		setup_a_rd[SPICFG_A_ADDR_INC_M] = addr_inc;
	end

	function automatic logic [7:0] read_mux(input logic [14:0] a,
		input logic [7:0] cfg_a, input logic [1:0] sel,
		input logic [2*SPICFG_CHANNELS-1:0] pwr);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			SPICFG_SETUP_A_ADDR: v = cfg_a;
			SPICFG_POWER_ADDR: v = {6'h00, sel[0] ? pwr[1:0] : pwr[3:2]};
			SPICFG_CHSEL_ADDR: v = {6'h00, sel};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	function automatic logic [14:0] rev15(input logic [14:0] x);
		logic [14:0] r;
		r = 15'h0000;
		for (int i = 0; i < SPICFG_ADDR_W; i++) begin
			r[i] = x[SPICFG_ADDR_W-1-i];
		end
		return r;
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] x);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < SPICFG_WORD_BITS; i++) begin
			r[i] = x[SPICFG_WORD_BITS-1-i];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [14:0] a;
		logic [7:0] wb;
		logic [14:0] step;
		a = 15'h0000;
		wb = 8'h00;
		step = 15'h0000;
		next_st = st;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_rw = rw;
		next_addr = addr;
		next_rd_byte = rd_byte;
		next_sdio_out = sdio_out;
		next_sdio_oe = sdio_oe;
		next_soft = 1'b0;
		next_dp = 1'b0;
		next_lsb_first = lsb_first;
		next_addr_inc = addr_inc;
		next_ch_sel = ch_sel;
		next_power = chan_power_mode;
		if (csb_s) begin
			next_st = SPICFG_ST_INSTR;
			next_bit_cnt = 4'h0;
			next_sdio_oe = 1'b0;
		end else begin
			unique case (st)
				SPICFG_ST_INSTR: begin
					if (rise) begin
						next_shreg = {shreg[14:0], sdi_s};
						if (bit_cnt == 4'hf) begin
							// Read/write flag is always the first bit
							next_rw = next_shreg[15];
							a = lsb_first ? rev15(next_shreg[14:0]) :
								next_shreg[14:0];
							next_addr = a;
							next_rd_byte = read_mux(a, setup_a_rd, ch_sel,
								chan_power_mode);
							next_bit_cnt = 4'h0;
							next_st = SPICFG_ST_DATA;
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
				end
				SPICFG_ST_DATA: begin
					if (rise) begin
						next_shreg = {shreg[14:0], sdi_s};
						if (bit_cnt == 4'h7) begin
							wb = lsb_first ? rev8(next_shreg[7:0]) :
								next_shreg[7:0];
							step = addr_inc ? addr + 15'h0001 :
								addr - 15'h0001;
							next_addr = step;
							next_bit_cnt = 4'h0;
							next_rd_byte = read_mux(step, setup_a_rd, ch_sel,
								chan_power_mode);
							// Unlisted offsets are dropped silently
							if (!rw) begin
								unique case (addr)
									SPICFG_SETUP_A_ADDR: begin
										next_lsb_first = wb[SPICFG_A_LSB_FIRST] |
											wb[SPICFG_A_LSB_FIRST_M];
										next_addr_inc = wb[SPICFG_A_ADDR_INC] |
											wb[SPICFG_A_ADDR_INC_M];
										if (wb[SPICFG_A_SOFT_RST] |
											wb[SPICFG_A_SOFT_RST_M]) begin
											next_soft = 1'b1;
											next_lsb_first = SPICFG_LSB_FIRST_RST;
											next_addr_inc = SPICFG_ADDR_INC_RST;
											next_ch_sel = SPICFG_CHSEL_RST;
											next_power = {2{SPICFG_POWER_RST}};
											// Rest of frame ignored until deselect
											next_st = SPICFG_ST_HOLD;
										end
									end
									SPICFG_SETUP_B_ADDR: begin
										next_dp = wb[SPICFG_B_DP_RST];
									end
									SPICFG_POWER_ADDR: begin
										for (int i = 0; i < SPICFG_CHANNELS; i++) begin
											if (ch_sel[i]) begin
												next_power[2*i+:2] = wb[1:0];
											end
										end
									end
									SPICFG_CHSEL_ADDR: next_ch_sel = wb[1:0];
									default: next_ch_sel = ch_sel;
								endcase
							end
						end else begin
							next_bit_cnt = bit_cnt + 4'h1;
						end
					end
					// Drive on the falling edge so the host samples on rising
					if (fall && rw) begin
						next_sdio_oe = 1'b1;
						next_sdio_out = lsb_first ? out_lsb :
							rd_byte[3'h7 - bit_cnt[2:0]];
					end
				end
				SPICFG_ST_HOLD: begin
					next_sdio_oe = 1'b0;
				end
				default: next_st = SPICFG_ST_HOLD;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= SPICFG_ST_INSTR;
			sclk_q <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 16'h0000;
			rw <= 1'b0;
			addr <= 15'h0000;
			rd_byte <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe <= 1'b0;
			soft_reset_pulse <= 1'b0;
			datapath_reset_pulse <= 1'b0;
			lsb_first <= SPICFG_LSB_FIRST_RST;
			addr_inc <= SPICFG_ADDR_INC_RST;
			ch_sel <= SPICFG_CHSEL_RST;
			chan_power_mode <= {2{SPICFG_POWER_RST}};
		end else begin
			st <= next_st;
			sclk_q <= sclk_s;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			rw <= next_rw;
			addr <= next_addr;
			rd_byte <= next_rd_byte;
			sdio_out <= next_sdio_out;
			sdio_oe <= next_sdio_oe;
			soft_reset_pulse <= next_soft;
			datapath_reset_pulse <= next_dp;
			lsb_first <= next_lsb_first;
			addr_inc <= next_addr_inc;
			ch_sel <= next_ch_sel;
			chan_power_mode <= next_power;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Code 01 is undefined and treated as normal operation
	generate
		for (genvar c = 0; c < SPICFG_CHANNELS; c++) begin : g_pwr
			assign datapath_clk_en[c] =
				chan_power_mode[2*c+:2] != SPICFG_PWR_STANDBY &&
				chan_power_mode[2*c+:2] != SPICFG_PWR_DOWN;
			assign datapath_hold_reset[c] =
				chan_power_mode[2*c+:2] == SPICFG_PWR_DOWN;
			assign link_enable[c] =
				chan_power_mode[2*c+:2] != SPICFG_PWR_DOWN;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_soft_clear;
		soft_reset_pulse |=> !soft_reset_pulse && st != SPICFG_ST_DATA;
	endproperty
	a_soft_clear: assert property (p_soft_clear) else $error("soft reset stuck");

	property p_soft_values;
		soft_reset_pulse |-> !lsb_first && !addr_inc && ch_sel == 2'h3 &&
			chan_power_mode == 4'h0;
	endproperty
	a_soft_values: assert property (p_soft_values) else $error("reset values");

	property p_dp_clear;
		datapath_reset_pulse |=> !datapath_reset_pulse;
	endproperty
	a_dp_clear: assert property (p_dp_clear) else $error("dp reset stuck");

	property p_pwr_down;
		datapath_hold_reset[0] |-> !datapath_clk_en[0] && !link_enable[0];
	endproperty
	a_pwr_down: assert property (p_pwr_down) else $error("power-down decode");

	property p_turn;
		sdio_oe |-> !$past(csb_s) && rw && st == SPICFG_ST_DATA;
	endproperty
	a_turn: assert property (p_turn) else $error("pin driven on write");

	property p_step;
		byte_done && addr_inc |=> addr == $past(addr) + 15'h0001;
	endproperty
	a_step: assert property (p_step) else $error("address step");

	property p_order;
		fall && rw && lsb_first && !csb_s && st == SPICFG_ST_DATA |=>
			sdio_out == $past(out_lsb);
	endproperty
	a_order: assert property (p_order) else $error("bit order");

	property p_mirror;
		setup_a_rd[6] == setup_a_rd[1] && setup_a_rd[5] == setup_a_rd[2] &&
			setup_a_rd[7] == 1'b0 && setup_a_rd[4:3] == 2'h0;
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bits");

	property p_both;
		byte_done && !rw && addr == SPICFG_POWER_ADDR && ch_sel == 2'h3 |=>
			chan_power_mode[1:0] == chan_power_mode[3:2];
	endproperty
	a_both: assert property (p_both) else $error("dual channel write");

	c_read: cover property (sdio_oe && byte_done);
	c_soft: cover property (soft_reset_pulse);
	c_multi: cover property (byte_done && !rw ##[1:300] byte_done);
	c_dp: cover property (datapath_reset_pulse);
endmodule // spicfg_regs

// ### sim/spicfg_host_model.sv
// SPI host model that drives the serial configuration port
`timescale 1ns/1ps
module spicfg_host_model #(
	parameter int HALF = 8,
	// Shortened boot wait; the device itself imposes none
	parameter int BOOT_WAIT = 200
) (
	// Clock
	input wire logic core_clk,
	// Serial pins
	output logic spi_sclk,
	output logic select_low_input_n,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe
);
	logic lsb = 1'b0;
	logic host_d = 1'b0;
	logic host_oe = 1'b0;
	logic last = 1'b0;
	initial begin
		spi_sclk = 1'b0;
		select_low_input_n = 1'b1;
	end
	// Released wire toggles so a stale level never reads as data
	assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : ~last);
	always @(posedge core_clk) begin
		last <= sdio_in;
	end
	//////////////////////////////////////////////////////////
	// Data changes with the fall, held a full half period
	task automatic bitx(input logic b, input logic drv, output logic s);
		@(posedge core_clk);
		host_d <= b;
		host_oe <= drv;
		spi_sclk <= 1'b0;
		repeat (HALF) @(posedge core_clk);
		s = sdio_in;
		spi_sclk <= 1'b1;
		repeat (HALF) @(posedge core_clk);
	endtask
	task automatic xfer(input logic rd, input logic [14:0] addr,
		input int n, input logic [7:0] wd [4], output logic [7:0] rdat [4]);
		logic s;
		if (!rd && !(addr inside {15'h0000, 15'h0001, 15'h0002, 15'h0008}))
			return;
		@(posedge core_clk);
		select_low_input_n <= 1'b0;
		repeat (HALF) @(posedge core_clk);
		bitx(rd, 1'b1, s);
		for (int i = 0; i < 15; i++)
			bitx(lsb ? addr[i] : addr[14-i], 1'b1, s);
		for (int k = 0; k < n; k++)
			for (int i = 0; i < 8; i++) begin
				bitx(lsb ? wd[k][i] : wd[k][7-i], !rd, s);
				rdat[k][lsb ? i : 7-i] = s;
			end
		@(posedge core_clk);
		spi_sclk <= 1'b0;
		host_oe <= 1'b0;
		repeat (HALF) @(posedge core_clk);
		select_low_input_n <= 1'b1;
		repeat (HALF) @(posedge core_clk);
	endtask
	task automatic wait_boot();
		repeat (BOOT_WAIT) @(posedge core_clk);
	endtask
endmodule // spicfg_host_model

// ### sim/spi_config_reset_regs_tb_top.sv
// Self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
module spi_config_reset_regs_tb_top;
	localparam int LIMIT = 40000;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic spi_sclk, select_low_input_n, sdio_in, sdio_out, sdio_oe;
	logic soft_reset_pulse, datapath_reset_pulse, lsb_first, addr_inc;
	logic [3:0] chan_power_mode;
	logic [1:0] datapath_clk_en, datapath_hold_reset, link_enable;
	logic [11:0] pins;
	logic [7:0] r [4];
	int bad_count = 0;
	int checked = 0;
	int sr_cnt = 0;
	int dp_cnt = 0;
	int cyc = 0;
	always #20 core_clk = ~core_clk;
	assign pins = {chan_power_mode, datapath_clk_en, datapath_hold_reset,
		link_enable, lsb_first, addr_inc};
	spicfg_regs u_spicfg_regs (
		.core_clk(core_clk), .rstn(rstn), .spi_sclk(spi_sclk),
		.select_low_input_n(select_low_input_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe),
		.soft_reset_pulse(soft_reset_pulse),
		.datapath_reset_pulse(datapath_reset_pulse),
		.lsb_first(lsb_first), .addr_inc(addr_inc),
		.chan_power_mode(chan_power_mode),
		.datapath_clk_en(datapath_clk_en),
		.datapath_hold_reset(datapath_hold_reset),
		.link_enable(link_enable)
	);
	spicfg_host_model #(.HALF(8), .BOOT_WAIT(200)) u_host (
		.core_clk(core_clk), .spi_sclk(spi_sclk),
		.select_low_input_n(select_low_input_n), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe)
	);
	//////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Pulses are one cycle wide, so counting edges sees each once
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (soft_reset_pulse === 1'b1) begin
			sr_cnt <= sr_cnt + 1;
		end
		if (datapath_reset_pulse === 1'b1) begin
			dp_cnt <= dp_cnt + 1;
		end
		if (cyc == LIMIT) begin
			bad_count++;
			$display("ERROR %0t run timed out", $time);
			finish_test();
		end
	end
	task automatic miss(input logic [11:0] g, input logic [11:0] e);
		bad_count++;
		$display("ERROR %0t got %h expected %h", $time, g, e);
	endtask
	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) miss({4'h0, g}, {4'h0, e});
	endtask
	task automatic chk_pins(input logic [11:0] e);
		checked++;
		if (pins !== e) miss(pins, e);
	endtask
	task automatic chk_cnt(input int g, input int e);
		checked++;
		if (g != e) miss(12'(g), 12'(e));
	endtask
	function automatic logic [11:0] exp_pins(input logic [3:0] pm,
		input logic l, input logic i);
		logic [1:0] ce, hr;
		for (int c = 0; c < 2; c++) begin
			ce[c] = !pm[2*c+1];
			hr[c] = &pm[2*c +: 2];
		end
		return {pm, ce, hr, ~hr, l, i};
	endfunction
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		u_host.xfer(1'b0, a, 1, '{d, 8'h00, 8'h00, 8'h00}, r);
		chk_reg({7'h00, sdio_oe}, 8'h00);
	endtask
	task automatic rd(input logic [14:0] a, input int n,
		input logic [7:0] e [4]);
		u_host.xfer(1'b1, a, n, '{4{8'h00}}, r);
		for (int k = 0; k < n; k++) chk_reg(r[k], e[k]);
	endtask
	//////////////////////////////////////////////////////////
	task automatic t_reset_vals();
		logic [14:0] ad [5] = '{15'h0, 15'h1, 15'h2, 15'h8, 15'h3};
		logic [7:0] ev [5] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
		chk_pins(exp_pins(4'h0, 1'b0, 1'b0));
		for (int i = 0; i < 5; i++) rd(ad[i], 1, '{ev[i], 0, 0, 0});
	endtask
	task automatic t_power();
		logic [7:0] cd [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
		for (int i = 0; i < 4; i++) begin
			wr(15'h2, cd[i]);
			chk_pins(exp_pins({cd[i][1:0], cd[i][1:0]}, 1'b0, 1'b0));
			rd(15'h2, 1, '{cd[i], 0, 0, 0});
		end
		wr(15'h8, 8'h02);
		wr(15'h2, 8'h00);
		chk_pins(exp_pins(4'h1, 1'b0, 1'b0));
		rd(15'h2, 1, '{8'h00, 0, 0, 0});
		wr(15'h8, 8'h03);
		rd(15'h2, 1, '{8'h01, 0, 0, 0});
	endtask
	task automatic t_dp_reset();
		int c;
		c = dp_cnt;
		wr(15'h1, 8'h02);
		chk_cnt(dp_cnt - c, 1);
		rd(15'h1, 1, '{8'h00, 0, 0, 0});
		wr(15'h1, 8'hfd);
		chk_cnt(dp_cnt - c, 1);
		wr(15'h2, 8'hfe);
		wr(15'h0, 8'h18);
		chk_pins(exp_pins(4'ha, 1'b0, 1'b0));
		rd(15'h2, 1, '{8'h02, 0, 0, 0});
		rd(15'h0, 1, '{8'h00, 0, 0, 0});
	endtask
	task automatic t_order();
		wr(15'h0, 8'h40);
		chk_pins(exp_pins(4'ha, 1'b1, 1'b0));
		u_host.lsb = 1'b1;
		wr(15'h2, 8'h02);
		rd(15'h2, 3, '{8'h02, 8'h00, 8'h42, 0});
		wr(15'h0, 8'h20);
		u_host.lsb = 1'b0;
		chk_pins(exp_pins(4'ha, 1'b0, 1'b1));
		rd(15'h1, 2, '{8'h00, 8'h02, 0, 0});
	endtask
	task automatic t_soft();
		logic [7:0] k [2] = '{8'h80, 8'h01};
		int c;
		for (int i = 0; i < 2; i++) begin
			wr(15'h8, 8'h01);
			wr(15'h2, 8'h03);
			c = sr_cnt;
			wr(15'h0, k[i]);
			u_host.wait_boot();
			chk_cnt(sr_cnt - c, 1);
			chk_pins(exp_pins(4'h0, 1'b0, 1'b0));
			rd(15'h8, 1, '{8'h03, 0, 0, 0});
			rd(15'h0, 1, '{8'h00, 0, 0, 0});
		end
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (8) @(posedge core_clk);
		t_reset_vals();
		t_power();
		t_dp_reset();
		t_order();
		t_soft();
		finish_test();
	end
endmodule // spi_config_reset_regs_tb_top
